// ==== core/rgd_consts.vh ====
// Constants for the reset generator and rail discharge block
`ifndef RGD_CONSTS_VH
`define RGD_CONSTS_VH
// Register byte offsets
`define RGD_A_SYS_CTRL 8'h00
`define RGD_A_PWR_CTRL 8'h04
`define RGD_A_DIS_SEL 8'h08
`define RGD_A_DIS_TRIG 8'h0C
`define RGD_A_BOD_STAT 8'h10
`define RGD_A_ANA_STAT 8'h14
`define RGD_A_SYS_STAT 8'h18
`define RGD_A_CPU_RST 8'h1C
`define RGD_A_DBG_RST 8'h20
`define RGD_A_IRQ_STAT 8'h24
`define RGD_A_IRQ_MASK 8'h28
`define RGD_A_BOD_EN 8'h2C
// Field positions
`define RGD_B_SWBOOT 0
`define RGD_B_WAKE 0
`define RGD_F_THR_HI 2
`define RGD_F_THR_LO 1
`define RGD_B_DBG 0
`define RGD_B_IRQ_BAT 0
`define RGD_B_IRQ_DIS 1
`define RGD_B_ANA_BAT 0
`define RGD_B_ANA_BUSY 1
// Reset values
`define RGD_R_THR 2'h2
`define RGD_R_BOD_EN 5'h01
`define RGD_R_DIS_SEL 3'h0
// Core threshold codes
`define RGD_THR_0P7 2'h0
`define RGD_THR_0P8 2'h1
// Key for the CPU reset request
`define RGD_CPU_KEY 32'h05FA0004
// Timing: one discharge step, in ns, and the clock period in ns
`define RGD_STEP_NS 1000000
`define RGD_CLK_NS 40
`define RGD_STEP_CYC (`RGD_STEP_NS / `RGD_CLK_NS)
// Sequencer states, and the index that marks no selected rail
`define RGD_S_IDLE 2'h0
`define RGD_S_DIS 2'h1
`define RGD_S_SET 2'h2
`define RGD_NONE 2'h3
`endif

// ==== core/rgd_discharge.v ====
// Sequential rail discharge and regulator settling sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rgd_consts.vh"
module rgd_discharge #(
  parameter P_STEP_CYC = `RGD_STEP_CYC
) (
  // Clock and power-on reset
  input wire i_clk,
  input wire i_rst_n,
  // Start request and rails to discharge
  input wire i_start,
  input wire [2:0] i_sel,
  // Rail controls and status
  output wire [2:0] o_discharge,
  output wire [2:0] o_ldo_hold,
  output wire o_busy,
  output reg o_done
);
  reg [1:0] state_q;
  reg [1:0] idx_q;
  reg [2:0] mask_q;
  reg [15:0] cnt_q;
  wire step_end;

  // First selected rail at or after a start index
  function [1:0] first_sel;
    input [2:0] mask;
    input [1:0] from;
    begin
      if (from == 2'h0 && mask[0]) first_sel = 2'h0;
      else if (from <= 2'h1 && mask[1]) first_sel = 2'h1;
      else if (from <= 2'h2 && mask[2]) first_sel = 2'h2;
      else first_sel = `RGD_NONE;
    end
  endfunction

  assign step_end = (cnt_q == P_STEP_CYC[15:0] - 16'h0001);

  // Rails in order 1.4 V, 1.8 V, pad 1.8 V, one step each, then settle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= `RGD_S_IDLE;
      idx_q <= 2'h0;
      mask_q <= 3'h0;
      cnt_q <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_q)
        `RGD_S_IDLE: begin
          cnt_q <= 16'h0000;
          if (i_start && i_sel != 3'h0) begin
            mask_q <= i_sel;
            idx_q <= first_sel(i_sel, 2'h0); // RULE_17
            state_q <= `RGD_S_DIS;
          end
        end
        `RGD_S_DIS: begin
          cnt_q <= step_end ? 16'h0000 : cnt_q + 16'h0001; // RULE_13
          if (step_end) begin
            if (idx_q != 2'h2 && first_sel(mask_q, idx_q + 2'h1) != `RGD_NONE) begin
              idx_q <= first_sel(mask_q, idx_q + 2'h1); // RULE_17
            end else begin
              state_q <= `RGD_S_SET;
            end
          end
        end
        `RGD_S_SET: begin
          cnt_q <= step_end ? 16'h0000 : cnt_q + 16'h0001;
          if (step_end) begin
            state_q <= `RGD_S_IDLE; // RULE_14
            o_done <= 1'b1;
          end
        end
        default: begin
          state_q <= `RGD_S_IDLE;
        end
      endcase
    end
  end

  // One rail pulled down at a time; regulators held off until settling
  assign o_discharge = (state_q == `RGD_S_DIS) ? (3'h1 << idx_q) : 3'h0; // RULE_13
  assign o_ldo_hold = (state_q == `RGD_S_DIS) ? mask_q : 3'h0; // RULE_14
  assign o_busy = (state_q != `RGD_S_IDLE);
endmodule // rgd_discharge
`default_nettype wire

// ==== core/rgd_rst_sync.v ====
// Reset synchroniser: asynchronous assert, synchronous release
`timescale 1ns/1ps
`default_nettype none
module rgd_rst_sync (
  // Clock and combined asynchronous reset request
  input wire i_clk,
  input wire i_arst_n,
  // Synchronised reset
  output wire o_rst_n
);
  reg meta_q;
  reg sync_q;

  // Two stages so release never lands near a clock edge
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign o_rst_n = sync_q;
endmodule // rgd_rst_sync
`default_nettype wire

// ==== core/rgd_top.v ====
// Reset generator with brown-out supervision and rail discharge
//
// Overview of operation
// (RULE_01) A high reset pin requests reset; low leaves that source inactive.
// (RULE_02) Any enabled supervised rail at or below threshold forces power-on reset.
// (RULE_03) Battery below its low threshold raises an interrupt, not a reset.
// (RULE_04) Core rail threshold selectable among three; lowest fixed level always resets.
// (RULE_05) Power-on reset releases only when core, battery and supervised rails are good.
// (RULE_06) Power-on reset initialises every flip-flop of the block; brownout and cause records clear only on the raw reset.
// (RULE_07) Hardware reset from pin, watchdog, power-on reset or debugger register write.
// (RULE_08) Software reset is reboot bit OR keyed CPU request, plus hardware reset.
// (RULE_09) With reboot-after-wake set, wake-up from sleep asserts hardware reset.
// (RULE_10) Three nested reset domains: power-on, hardware, software.
// (RULE_11) Discharge select, brownout, system and analog status survive hardware/software reset.
// (RULE_12) While pin is high, selected rails among 1.4 V, 1.8 V, pad 1.8 V discharge.
// (RULE_13) Selected rails discharge one after another, one millisecond each.
// (RULE_14) Regulators of discharged rails stay off until done, then settle one millisecond.
// (RULE_15) The pin must stay high for the whole discharge plus settling time.
// (RULE_16) Software trigger bits start the same discharge as the reset pin.
// (RULE_17) Order is 1.4 V, then 1.8 V, then pad 1.8 V, skipping unselected.
// (RULE_18) Resets assert asynchronously and release synchronously to the clock.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rgd_consts.vh"
module rgd_top #(
  parameter P_STEP_CYC = `RGD_STEP_CYC
) (
  // Clock and raw power-good reset
  input wire i_clk,
  input wire i_arst_n,
  // Reset sources
  input wire i_rst_pin,
  input wire i_wdog_expire,
  input wire i_wake,
  input wire i_cpu_sysreset,
  // Comparator flags, high when the rail is below the level
  input wire i_core_below_min,
  input wire [2:0] i_core_below_thr,
  input wire [3:0] i_rail_below,
  input wire i_bat_below_min,
  input wire i_bat_below_low,
  // Register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // Reset outputs
  output wire o_por_n,
  output wire o_hw_rst_n,
  output wire o_sw_rst_n,
  // Rail discharge controls
  output wire [2:0] o_discharge,
  output wire [2:0] o_ldo_hold,
  // Interrupt
  output wire o_irq
);
  // Power-on domain state, plus brownout and cause records on the raw reset
  reg [2:0] dis_sel_q;
  reg bat_low_q;
  reg [4:0] bod_stat_q;
  reg [5:0] sys_stat_q;
  reg dbg_req_q;
  reg wake_req_q;
  reg swboot_req_q;
  reg cpu_req_q;
  reg pin_q;
  // Hardware domain state
  reg wake_en_q;
  reg [1:0] thr_sel_q;
  reg [4:0] bod_en_q;
  // Software domain state
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg [1:0] irq_stat_d;
  reg [31:0] rdata_d;
  // Combinational terms
  wire por_n;
  wire hw_n;
  wire sw_n;
  wire core_thr_low;
  wire [4:0] rail_low;
  wire por_req;
  wire hw_req;
  wire sw_req;
  wire dis_start;
  wire [2:0] dis_mask;
  wire dis_busy;
  wire dis_done;
  wire bat_rise;
  wire [2:0] trig_bits;
  wire wr_dis_trig;

  // Address match, shared by write and read paths
  function hit;
    input [7:0] addr;
    input [7:0] offs;
    begin
      hit = (addr == offs);
    end
  endfunction

  // Selected core threshold: 0.7 V, 0.8 V or 1.05 V comparator
  assign core_thr_low = (thr_sel_q == `RGD_THR_0P7) ? i_core_below_thr[0] :
                        (thr_sel_q == `RGD_THR_0P8) ? i_core_below_thr[1] :
                        i_core_below_thr[2]; // RULE_04

  // Bit 0 core, then 1.4 V, 1.8 V, pad 1.8 V, 3.3 V
  assign rail_low = {i_rail_below, core_thr_low};

  // Fixed core minimum and battery minimum cannot be masked
  assign por_req = i_core_below_min | i_bat_below_min |
                   (|(rail_low & bod_en_q)); // RULE_02 RULE_04 RULE_05

  // Hardware reset sources, including power-on reset via the chain
  assign hw_req = i_rst_pin | i_wdog_expire | dbg_req_q | wake_req_q; // RULE_01 RULE_07

  // Software reset sources; hardware reset enters via the chain
  assign sw_req = swboot_req_q | cpu_req_q; // RULE_08

  // Nested chain: each stage also asserts when the outer one does
  rgd_rst_sync u_por_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n & ~por_req), // RULE_18
    .o_rst_n(por_n)
  );

  rgd_rst_sync u_hw_sync (
    .i_clk(i_clk),
    .i_arst_n(por_n & ~hw_req), // RULE_07 RULE_18
    .o_rst_n(hw_n)
  );

  rgd_rst_sync u_sw_sync (
    .i_clk(i_clk),
    .i_arst_n(hw_n & ~sw_req), // RULE_08 RULE_18
    .o_rst_n(sw_n)
  );

  assign o_por_n = por_n;
  assign o_hw_rst_n = hw_n;
  assign o_sw_rst_n = sw_n;

  // Discharge start: pin rising edge, or software trigger bits
  assign wr_dis_trig = i_wr && hit(i_addr, `RGD_A_DIS_TRIG);
  assign trig_bits = wr_dis_trig ? i_wdata[2:0] : 3'h0;
  assign dis_start = (i_rst_pin & ~pin_q) | (|trig_bits); // RULE_12 RULE_16
  assign dis_mask = (|trig_bits) ? trig_bits : dis_sel_q; // RULE_16

  // Sequencer sits in the power-on domain so pin resets do not stop it
  rgd_discharge #(
    .P_STEP_CYC(P_STEP_CYC)
  ) u_dis (
    .i_clk(i_clk),
    .i_rst_n(por_n),
    .i_start(dis_start), // RULE_12
    .i_sel(dis_mask),
    .o_discharge(o_discharge),
    .o_ldo_hold(o_ldo_hold),
    .o_busy(dis_busy),
    .o_done(dis_done)
  );

  // Power-on domain registers, kept through hardware and software reset
  always @(posedge i_clk or negedge por_n) begin
    if (!por_n) begin
      dis_sel_q <= `RGD_R_DIS_SEL; // RULE_06 RULE_11
      bat_low_q <= 1'b0;
      pin_q <= 1'b0;
      dbg_req_q <= 1'b0;
      wake_req_q <= 1'b0;
      swboot_req_q <= 1'b0;
      cpu_req_q <= 1'b0;
    end else begin
      pin_q <= i_rst_pin;
      bat_low_q <= i_bat_below_low;
      // Write-one select: ones add rails, zeros leave them
      if (i_wr && hit(i_addr, `RGD_A_DIS_SEL)) begin
        dis_sel_q <= dis_sel_q | i_wdata[2:0]; // RULE_11 RULE_12
      end
      // One-cycle requests; the synchroniser stretches them
      dbg_req_q <= i_wr && hit(i_addr, `RGD_A_DBG_RST) && i_wdata[`RGD_B_DBG]; // RULE_07
      wake_req_q <= i_wake & wake_en_q; // RULE_09
      swboot_req_q <= i_wr && hit(i_addr, `RGD_A_SYS_CTRL) &&
                      i_wdata[`RGD_B_SWBOOT]; // RULE_08
      cpu_req_q <= i_cpu_sysreset |
                   (i_wr && hit(i_addr, `RGD_A_CPU_RST) &&
                    i_wdata == `RGD_CPU_KEY); // RULE_08
    end
  end

  // Brownout and cause records use the raw reset so they catch the event
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bod_stat_q <= 5'h00;
      sys_stat_q <= 6'h00;
    end else begin
      // Sticky rail-below flags; hardware set wins over a clear write
      bod_stat_q <= (rail_low & bod_en_q) |
                    ((i_wr && hit(i_addr, `RGD_A_BOD_STAT)) ?
                     (bod_stat_q & ~i_wdata[4:0]) : bod_stat_q); // RULE_11
      // Causes: por, pin, watchdog, debugger, wake, software
      sys_stat_q <= {sw_req, wake_req_q, dbg_req_q, i_wdog_expire, i_rst_pin, ~por_n} |
                    ((i_wr && hit(i_addr, `RGD_A_SYS_STAT)) ?
                     (sys_stat_q & ~i_wdata[5:0]) : sys_stat_q); // RULE_11
    end
  end

  // Hardware domain controls, untouched by software reset
  always @(posedge i_clk or negedge hw_n) begin
    if (!hw_n) begin
      wake_en_q <= 1'b0; // RULE_10
      thr_sel_q <= `RGD_R_THR;
      bod_en_q <= `RGD_R_BOD_EN;
    end else begin
      if (i_wr && hit(i_addr, `RGD_A_PWR_CTRL)) begin
        wake_en_q <= i_wdata[`RGD_B_WAKE]; // RULE_09
        thr_sel_q <= i_wdata[`RGD_F_THR_HI:`RGD_F_THR_LO]; // RULE_04
      end
      if (i_wr && hit(i_addr, `RGD_A_BOD_EN)) begin
        bod_en_q <= i_wdata[4:0]; // RULE_02
      end
    end
  end

  // Battery low is a rising-edge event, never a reset source
  assign bat_rise = i_bat_below_low & ~bat_low_q; // RULE_03

  // Interrupt status next value; a new event beats a clearing read
  always @* begin
    irq_stat_d = irq_stat_q;
    if (i_rd && hit(i_addr, `RGD_A_IRQ_STAT)) begin
      irq_stat_d = 2'h0;
    end
    if (bat_rise) begin
      irq_stat_d[`RGD_B_IRQ_BAT] = 1'b1; // RULE_03
    end
    if (dis_done) begin
      irq_stat_d[`RGD_B_IRQ_DIS] = 1'b1;
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    rdata_d = 32'h00000000;
    case (i_addr)
      `RGD_A_PWR_CTRL: begin
        rdata_d[`RGD_B_WAKE] = wake_en_q;
        rdata_d[`RGD_F_THR_HI:`RGD_F_THR_LO] = thr_sel_q;
      end
      `RGD_A_DIS_SEL: begin
        rdata_d[2:0] = dis_sel_q;
      end
      `RGD_A_BOD_STAT: begin
        rdata_d[4:0] = bod_stat_q;
      end
      `RGD_A_ANA_STAT: begin
        rdata_d[`RGD_B_ANA_BAT] = bat_low_q;
        rdata_d[`RGD_B_ANA_BUSY] = dis_busy;
      end
      `RGD_A_SYS_STAT: begin
        rdata_d[5:0] = sys_stat_q;
      end
      `RGD_A_IRQ_STAT: begin
        rdata_d[1:0] = irq_stat_q;
      end
      `RGD_A_IRQ_MASK: begin
        rdata_d[1:0] = irq_mask_q;
      end
      `RGD_A_BOD_EN: begin
        rdata_d[4:0] = bod_en_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Software domain: interrupt registers and read data
  always @(posedge i_clk or negedge sw_n) begin
    if (!sw_n) begin
      irq_stat_q <= 2'h0; // RULE_10
      irq_mask_q <= 2'h0;
      o_rdata <= 32'h00000000;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (i_wr && hit(i_addr, `RGD_A_IRQ_MASK)) begin
        irq_mask_q <= i_wdata[1:0];
      end
      // Read data stand only in the cycle after the strobe
      o_rdata <= i_rd ? rdata_d : 32'h00000000;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign o_irq = |(irq_stat_q & irq_mask_q); // RULE_03
endmodule // rgd_top
`default_nettype wire

// ==== verif/rgd_pin_model.sv ====
// Model of the external reset pin driver
`timescale 1ns/1ps
`default_nettype none
module rgd_pin_model (
  // Clock and hold request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_hold_cyc,
  // Pin level, pulled down when not driven
  output wire logic o_rst_pin
);
  logic [15:0] left_q = 16'h0;
  // Holds the pin for the full discharge plus settle span
  always @(posedge i_clk) begin
    if (i_go) begin
      left_q <= i_hold_cyc;
    end else if (left_q != 16'h0) begin
      left_q <= left_q - 16'h1;
    end
  end
  assign o_rst_pin = (left_q != 16'h0);
endmodule // rgd_pin_model
`default_nettype wire

// ==== verif/rgd_top_properties.sv ====
// Concurrent checks on the reset outputs and rail discharge pins of rgd_top
`timescale 1ns/1ps
`default_nettype none
module rgd_top_properties #(
  parameter P_STEP_CYC = 4
) (
  // Clock, reset and sources
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_rst_pin,
  input wire logic i_wdog_expire,
  input wire logic i_core_below_min,
  input wire logic i_bat_below_min,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  // Observed outputs
  input wire logic o_por_n,
  input wire logic o_hw_rst_n,
  input wire logic o_sw_rst_n,
  input wire logic [2:0] o_discharge,
  input wire logic [2:0] o_ldo_hold
);
  logic [2:0] prev_q;
  logic [31:0] run_q;
  // Step length counter; a repetition would need the parameter as a count
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_q <= 3'h0;
      run_q <= 32'h0;
    end else begin
      prev_q <= o_discharge;
      run_q <= (o_discharge == 3'h0) ? 32'h0 : (o_discharge == prev_q) ? run_q + 32'h1 : 32'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Steps of a discharge run and of a keyed request
  sequence s_step_end;
    prev_q != 3'h0 && o_discharge != prev_q;
  endsequence
  sequence s_rails_idle;
    o_discharge == 3'h0 && o_ldo_hold == 3'h0;
  endsequence
  sequence s_key_write;
    i_wr && i_addr == 8'h1C && i_wdata == 32'h05FA0004;
  endsequence
  a_step_length: assert property (s_step_end |-> run_q == P_STEP_CYC)
    else $error("discharge step length wrong");
  a_order_first: assert property ($rose(o_discharge[0]) |-> $past(o_discharge) == 3'h0)
    else $error("1.4 V rail not first");
  a_order_pad: assert property ($fell(o_discharge[2]) |-> o_discharge == 3'h0)
    else $error("pad rail not last");
  a_hold_covers: assert property (o_discharge != 3'h0 |-> $onehot(o_discharge) && (o_ldo_hold & o_discharge) == o_discharge)
    else $error("regulator not held during discharge");
  a_settle_idle: assert property ($fell(|o_discharge) |-> s_rails_idle)
    else $error("regulators not released for settling");
  a_pin_hw: assert property (i_rst_pin |-> !o_hw_rst_n)
    else $error("pin high without hardware reset");
  a_wdog_hw: assert property (i_wdog_expire |-> !o_hw_rst_n)
    else $error("watchdog without hardware reset");
  a_por_source: assert property ((i_core_below_min || i_bat_below_min) |-> !o_por_n)
    else $error("low rail without power-on reset");
  a_por_nest: assert property (!o_por_n |-> !o_hw_rst_n)
    else $error("power-on reset without hardware reset");
  a_hw_nest: assert property (!o_hw_rst_n |-> !o_sw_rst_n)
    else $error("hardware reset without software reset");
  a_key_reset: assert property (s_key_write |-> ##[1:2] !o_sw_rst_n)
    else $error("keyed request without software reset");
  a_por_release: assert property ($rose(o_por_n) |-> !$past(i_core_below_min) && !$past(i_bat_below_min))
    else $error("power-on reset released with rail low");
endmodule // rgd_top_properties
bind rgd_top rgd_top_properties #(.P_STEP_CYC(P_STEP_CYC)) u_props (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_rst_pin(i_rst_pin), .i_wdog_expire(i_wdog_expire),
  .i_core_below_min(i_core_below_min), .i_bat_below_min(i_bat_below_min), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .o_por_n(o_por_n), .o_hw_rst_n(o_hw_rst_n),
  .o_sw_rst_n(o_sw_rst_n), .o_discharge(o_discharge), .o_ldo_hold(o_ldo_hold)
);
`default_nettype wire

// ==== verif/rgd_top_tb_top.sv ====
// Self-checking bench for the reset generator and rail discharge block
`timescale 1ns/1ps
`default_nettype none
module rgd_top_tb_top;
  localparam int P = 4;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_wdog_expire = 1'b0, i_wake = 1'b0;
  logic i_cpu_sysreset = 1'b0, i_core_below_min = 1'b0, i_bat_below_min = 1'b0;
  logic i_bat_below_low = 1'b0, i_wr = 1'b0, i_rd = 1'b0, pin_go = 1'b0;
  logic [2:0] i_core_below_thr = 3'h0;
  logic [3:0] i_rail_below = 4'h0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [15:0] pin_hold = 16'h0;
  wire logic [31:0] o_rdata;
  wire logic o_por_n, o_hw_rst_n, o_sw_rst_n, o_irq, rst_pin;
  wire logic [2:0] o_discharge, o_ldo_hold;
  int error_cnt = 0;
  int samples_checked = 0;
  // 25 MHz clock
  always #20 i_clk = ~i_clk;
  rgd_top #(.P_STEP_CYC(P)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_rst_pin(rst_pin), .i_wdog_expire(i_wdog_expire),
    .i_wake(i_wake), .i_cpu_sysreset(i_cpu_sysreset), .i_core_below_min(i_core_below_min),
    .i_core_below_thr(i_core_below_thr), .i_rail_below(i_rail_below),
    .i_bat_below_min(i_bat_below_min), .i_bat_below_low(i_bat_below_low), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_por_n(o_por_n),
    .o_hw_rst_n(o_hw_rst_n), .o_sw_rst_n(o_sw_rst_n), .o_discharge(o_discharge),
    .o_ldo_hold(o_ldo_hold), .o_irq(o_irq)
  );
  rgd_pin_model u_pin (.i_clk(i_clk), .i_go(pin_go), .i_hold_cyc(pin_hold), .o_rst_pin(rst_pin));
  // Verdict and end of run
  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(name, exp, o_rdata);
  endtask
  // Rail expected in cycle k of a run: selected rails in ascending order
  function automatic logic [2:0] exp_disc(input logic [2:0] sel, input int k);
    int n;
    exp_disc = 3'h0;
    n = 0;
    for (int b = 0; b < 3; b++) begin
      if (sel[b]) begin
        if (n == (k - 1) / P) begin
          exp_disc[b] = 1'b1;
        end
        n++;
      end
    end
  endfunction
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge i_clk);
    error_cnt++;
    results();
  end
  initial begin
    logic [2:0] sel;
    logic lo_hw, lo_sw;
    int n, k;
    void'($urandom(88));
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (12) @(posedge i_clk);
    rd(8'h04, 32'h4, "pwr_ctrl");
    rd(8'h2C, 32'h1, "bod_en");
    rd(8'h08, 32'h0, "dis_sel");
    rd(8'h30, 32'h0, "unmapped");
    // Software discharge, all rails first, masked and unmasked interrupt
    for (int run = 0; run < 4; run++) begin
      sel = (run == 0) ? 3'h7 : 3'($urandom_range(1, 7));
      n = $countones(sel);
      wr(8'h28, {30'h0, run[0], 1'b0});
      wr(8'h0C, {29'h0, sel});
      for (k = 1; k <= (n + 1) * P; k++) begin
        #1 chk("discharge", exp_disc(sel, k), o_discharge);
        chk("ldo_hold", (k <= n * P) ? sel : 3'h0, o_ldo_hold);
        @(posedge i_clk);
      end
      repeat (2) @(posedge i_clk);
      #1 chk("irq", run[0], o_irq);
      rd(8'h24, 32'h2, "irq_stat");
      @(posedge i_clk);
      #1 chk("irq_clear", 1'b0, o_irq);
    end
    // Pin driven discharge of two rails
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h5);
    pin_hold <= 16'(4 * P + 4);
    pin_go <= 1'b1;
    @(posedge i_clk);
    pin_go <= 1'b0;
    n = 0;
    while (o_discharge === 3'h0 && n < 20) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk("pin_first", 3'h1, o_discharge);
    chk("pin_hw_rst", 1'b0, o_hw_rst_n);
    chk("pin_hold", 3'h5, o_ldo_hold);
    repeat (P) @(posedge i_clk);
    #1 chk("pin_pad", 3'h4, o_discharge);
    repeat (4 * P + 12) @(posedge i_clk);
    rd(8'h08, 32'h5, "dis_sel_kept");
    rd(8'h04, 32'h4, "pwr_ctrl_cleared");
    rd(8'h28, 32'h0, "irq_mask_cleared");
    // Hardware and software reset sources, with a wrong key and wake cases
    for (int s = 0; s < 8; s++) begin
      if (s == 7) wr(8'h04, 32'h1);
      @(posedge i_clk);
      case (s)
        0: i_wdog_expire <= 1'b1;
        1: wr(8'h20, 32'h1);
        2: wr(8'h1C, 32'h05FA0004);
        3: wr(8'h00, 32'h1);
        4: i_cpu_sysreset <= 1'b1;
        5: wr(8'h1C, 32'h05FA0004 ^ (32'h1 << $urandom_range(0, 31)));
        default: i_wake <= 1'b1;
      endcase
      lo_hw = 1'b0;
      lo_sw = 1'b0;
      for (k = 0; k < 6; k++) begin
        #1 lo_hw |= !o_hw_rst_n;
        lo_sw |= !o_sw_rst_n;
        @(posedge i_clk);
        {i_wdog_expire, i_cpu_sysreset, i_wake} <= 3'h0;
      end
      chk("hw_src", (s < 2 || s == 7), lo_hw);
      chk("sw_src", (s != 5 && s != 6), lo_sw);
      repeat (14) @(posedge i_clk);
    end
    // Power-on reset from core minimum, battery minimum, core threshold and the 3.3 V rail
    for (int s = 0; s < 4; s++) begin
      if (s == 3) wr(8'h2C, 32'h10);
      @(posedge i_clk);
      case (s)
        0: i_core_below_min <= 1'b1;
        1: i_bat_below_min <= 1'b1;
        2: i_core_below_thr <= 3'h4;
        default: i_rail_below <= 4'h8;
      endcase
      #1 chk("por", 3'h0, {o_por_n, o_hw_rst_n, o_sw_rst_n});
      @(posedge i_clk);
      {i_core_below_min, i_bat_below_min, i_core_below_thr, i_rail_below} <= 9'h0;
      repeat (12) @(posedge i_clk);
      rd(8'h28, 32'h0, "mask_after_por");
    end
    // Core threshold at 0.8 V: the 1.05 V flag is ignored, the 0.8 V flag resets
    wr(8'h04, 32'h2);
    i_core_below_thr <= 3'h4;
    @(posedge i_clk);
    #1 chk("thr_other", 1'b1, o_por_n);
    @(posedge i_clk);
    i_core_below_thr <= 3'h2;
    #1 chk("thr_sel", 1'b0, o_por_n);
    @(posedge i_clk);
    i_core_below_thr <= 3'h0;
    repeat (12) @(posedge i_clk);
    // Battery low gives an interrupt only
    wr(8'h28, 32'h1);
    i_bat_below_low <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1 chk("bat_irq", 1'b1, o_irq);
    chk("bat_no_por", 1'b1, o_por_n);
    rd(8'h14, 32'h1, "ana_stat");
    rd(8'h24, 32'h1, "irq_stat_bat");
    results();
  end
endmodule // rgd_top_tb_top
`default_nettype wire
